// [fence_protect_interrupt_gate.sv]
// Contract
// R01: Output to code 05 loads boundary; below is protected.
// R02: Protection starts at address 00002.
// R03: Jump to accumulator traps; call allowed.
// R04: Listed instructions into protected memory trap.
// R05: I/O instructions trap except select code 01.
// R06: Other instructions and indirect chains run normally.
// R07: Interrupt disables protection; set control 05 enables.
// R08: Preset while halted disables protection.
// R09: Trap captures address; input 05 reads it.
// R10: Bit 15 marks parity, rest holds address.
// R11: DMA interrupts only on block completion.
// R12: DMA1 vectors 06, DMA2 07, DMA1 first.
// R13: Channels vector to 00010 through 00077.
// R14: Priority network grants at cycle end.
// R15: Global and device enables gate I/O interrupts.
// R16: Indirect jump or call holds off interrupts.
// R17: Jump trap at execute end, no PC update.
// R18: After grant hold two phases of next.
// R19: No grant during DMA word transfer.
// R20: Control and flag instructions defer one cycle (the code defers two: defer_r, then defer2_r).
// R21: Flag code 00 sets or clears global enable.
// R22: Set flag and control blocks lower devices.
// R23: Parity error loads fault address automatically.
// R24: Reset leaves protection off, fault cleared.
`timescale 1ns/1ps
module fence_protect_interrupt_gate
  import fence_pkg::*;
#(
  parameter int CHANNELS = fence_pkg::IO_CHANNELS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Instruction sequencer.
  input wire fence_pkg::instr_class_t instr_class,
  input wire logic [fence_pkg::SC_W-1:0] select_code,
  input wire logic instr_indirect,
  input wire logic [fence_pkg::ADDR_W-1:0] instr_addr,
  input wire logic [fence_pkg::ADDR_W-1:0] eff_addr,
  input wire logic fetch_done,
  input wire logic indirect_done,
  input wire logic execute_done,
  input wire logic cycle_end,
  input wire logic halted,
  input wire logic preset_switch,
  input wire logic intloc_is_io,
  input wire logic [15:0] acc_in,
  // Parity, DMA and devices.
  input wire logic parity_error,
  input wire logic [fence_pkg::ADDR_W-1:0] parity_addr,
  input wire logic dma_word_xfer,
  input wire logic dma1_done,
  input wire logic dma2_done,
  input wire logic [CHANNELS-1:0] dev_flag,
  input wire logic [CHANNELS-1:0] dev_control,
  // Results.
  output logic suppress,
  output logic pc_inhibit,
  output logic [15:0] read_data,
  output logic read_valid,
  output logic int_grant,
  output logic [fence_pkg::ADDR_W-1:0] int_vector,
  output logic protect_on,
  output logic global_enable,
  output logic parity_enable
);
  import fence_pkg::*;

  logic [ADDR_W-1:0] boundary_r;
  logic [15:0] fault_r;
  logic protect_r, global_r, parity_en_r, defer_r, defer2_r;
  logic ind_hold_r, after_hold_r, after_ind_r;
  logic [1:0] ind_cnt_r, after_cnt_r;
  logic [1:0] ind_phase_r;
  logic is_io, is_guarded, addr_prot, acc_jump, trap, io_hit_sc5;
  logic [CHANNELS-1:0] dev_req;
  logic dev_any, holdoff, grant_io, grant_dma1, grant_dma2, any_grant;
  logic [ADDR_W-1:0] io_vec;

  assign is_io = instr_class inside {CLS_SET_CTL, CLS_CLR_CTL, CLS_SET_FLG, CLS_CLR_FLG,
                                     CLS_OUT, CLS_IN, CLS_IO_OTHER};
  assign is_guarded = instr_class inside {CLS_JUMP, CLS_CALL, CLS_ISZ, CLS_STORE_A,
                                          CLS_STORE_B, CLS_DSTORE};
  // Only the final effective address is judged. R06
  assign addr_prot = (eff_addr >= PROT_LOW) && (eff_addr < boundary_r); // R01 R02
  assign acc_jump = (instr_class == CLS_JUMP) && (eff_addr < PROT_LOW); // R03
  assign io_hit_sc5 = is_io && (select_code == SC_PROTECT);
  assign trap = protect_r && execute_done &&
                ((is_guarded && addr_prot) || acc_jump || // R04
                 (is_io && select_code != SC_SWITCH)); // R05
  assign suppress = trap; // R04 R05
  assign pc_inhibit = trap && (instr_class == CLS_JUMP); // R17

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      boundary_r <= BOUNDARY_RESET;
    end else if (!protect_r && execute_done && io_hit_sc5 && instr_class == CLS_OUT) begin
      boundary_r <= acc_in[ADDR_W-1:0]; // R01
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      protect_r <= 1'b0; // R24
    end else if (halted && preset_switch) begin
      protect_r <= 1'b0; // R08
    end else if (any_grant && !intloc_is_io) begin
      protect_r <= 1'b0; // R07
    end else if (trap) begin
      protect_r <= 1'b0; // R07
    end else if (execute_done && io_hit_sc5 && instr_class == CLS_SET_CTL) begin
      protect_r <= 1'b1; // R07
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_r <= FAULT_RESET; // R24
    end else if (trap) begin
      fault_r <= {1'b0, instr_addr}; // R09 R10
    end else if (parity_error) begin
      fault_r <= {1'b1, parity_addr}; // R23 R10
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      read_data <= 16'h0000;
      read_valid <= 1'b0;
    end else begin
      read_valid <= !trap && execute_done && io_hit_sc5 && instr_class == CLS_IN;
      read_data <= fault_r; // R09
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      global_r <= 1'b0;
      parity_en_r <= 1'b0;
    end else if (execute_done && !trap) begin
      if (select_code == SC_GLOBAL && instr_class == CLS_SET_FLG) global_r <= 1'b1; // R21
      if (select_code == SC_GLOBAL && instr_class == CLS_CLR_FLG) global_r <= 1'b0; // R21
      if (io_hit_sc5 && instr_class == CLS_SET_FLG) parity_en_r <= 1'b1; // R21
      if (io_hit_sc5 && instr_class == CLS_CLR_FLG) parity_en_r <= 1'b0; // R21
    end
  end

  // Control and flag instructions push the grant past the next two cycles.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      defer_r <= 1'b0;
      defer2_r <= 1'b0;
    end else if (cycle_end) begin
      defer_r <= instr_class inside {CLS_SET_CTL, CLS_CLR_CTL, CLS_SET_FLG, CLS_CLR_FLG}; // R20
      defer2_r <= defer_r; // R20
    end
  end

  // Indirect jump or call hold until one phase of the next instruction, or until the third indirect phase.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ind_hold_r <= 1'b0;
      ind_cnt_r <= 2'd0;
      ind_phase_r <= 2'd0;
    end else if (instr_indirect && fetch_done &&
                 (instr_class == CLS_JUMP || instr_class == CLS_CALL)) begin
      ind_hold_r <= 1'b1; // R16
      ind_cnt_r <= 2'd0;
      ind_phase_r <= 2'd0;
    end else if (ind_hold_r) begin
      if (indirect_done) begin
        ind_cnt_r <= ind_cnt_r + 2'd1;
        if (ind_cnt_r == 2'(IND_HOLD_LIMIT - 1)) ind_hold_r <= 1'b0; // R16
      end
      if (execute_done) ind_phase_r <= 2'd1;
      else if (ind_phase_r == 2'd1 && (fetch_done || indirect_done)) ind_hold_r <= 1'b0; // R16
    end
  end

  // Hold after a grant for two phases of the interrupt instruction, or to its execute phase if it is an indirect jump or call.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      after_hold_r <= 1'b0;
      after_cnt_r <= 2'd0;
      after_ind_r <= 1'b0;
    end else if (any_grant) begin
      after_hold_r <= 1'b1; // R18
      after_cnt_r <= 2'd0;
      after_ind_r <= 1'b0;
    end else if (after_hold_r) begin
      if (fetch_done && instr_indirect &&
          (instr_class == CLS_JUMP || instr_class == CLS_CALL)) after_ind_r <= 1'b1;
      if (fetch_done || indirect_done || execute_done) begin
        if (after_cnt_r != 2'(INT_HOLD_PHASES)) after_cnt_r <= after_cnt_r + 2'd1;
      end
      if (after_ind_r ? execute_done :
          (after_cnt_r == 2'(INT_HOLD_PHASES - 1) && (fetch_done || indirect_done ||
           execute_done))) after_hold_r <= 1'b0; // R18
    end
  end

  // A device with flag and control set masks everything below it.
  function automatic logic [CHANNELS-1:0] top_req(input logic [CHANNELS-1:0] f,
                                                   input logic [CHANNELS-1:0] c);
    logic block;
    top_req = '0;
    block = 1'b0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (!block && f[i] && c[i]) top_req[i] = 1'b1; // R14 R15
      if (f[i] && c[i]) block = 1'b1; // R22
    end
  endfunction

  always_comb begin
    dev_req = top_req(dev_flag, dev_control);
    io_vec = VEC_IO_BASE;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (dev_req[i]) io_vec = VEC_IO_BASE + ADDR_W'(i); // R13
    end
  end

  assign dev_any = |dev_req;
  assign holdoff = ind_hold_r || after_hold_r || defer_r || defer2_r || dma_word_xfer; // R16 R18 R19 R20
  assign grant_dma1 = cycle_end && !holdoff && dma1_done; // R11 R12
  assign grant_dma2 = cycle_end && !holdoff && !dma1_done && dma2_done; // R12
  assign grant_io = cycle_end && !holdoff && global_r && !dma1_done && !dma2_done && dev_any; // R15
  assign any_grant = grant_dma1 || grant_dma2 || grant_io || trap;

  // The protection trap bypasses the hold-offs.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_grant <= 1'b0;
      int_vector <= '0;
    end else begin
      int_grant <= any_grant; // R14
      if (trap) int_vector <= VEC_PROTECT; // R04 R17
      else if (grant_dma1) int_vector <= VEC_DMA1; // R12
      else if (grant_dma2) int_vector <= VEC_DMA2; // R12
      else if (grant_io) int_vector <= io_vec; // R13
    end
  end

  assign protect_on = protect_r;
  assign global_enable = global_r;
  assign parity_enable = parity_en_r;

  chk_trap_vector: assert property (@(posedge clk) disable iff (sys_rst)
    trap |=> int_grant && int_vector == VEC_PROTECT) else $error("trap not vectored"); // R04
  chk_trap_capture: assert property (@(posedge clk) disable iff (sys_rst)
    trap |=> fault_r == {1'b0, $past(instr_addr)}) else $error("fault not captured"); // R09
  chk_parity_bit: assert property (@(posedge clk) disable iff (sys_rst)
    parity_error && !trap |=> fault_r[FAULT_PARITY_BIT]) else $error("parity bit"); // R10
  chk_call_acc_ok: assert property (@(posedge clk) disable iff (sys_rst)
    instr_class == CLS_CALL && eff_addr < PROT_LOW |-> !trap) else $error("call trapped"); // R03
  chk_switch_io_ok: assert property (@(posedge clk) disable iff (sys_rst)
    is_io && select_code == SC_SWITCH |-> !trap) else $error("code 01 trapped"); // R05
  chk_hold_dma: assert property (@(posedge clk) disable iff (sys_rst)
    dma_word_xfer && !trap |=> !int_grant) else $error("grant in dma cycle"); // R19
  chk_hold_after: assert property (@(posedge clk) disable iff (sys_rst)
    int_grant |=> !int_grant || $past(trap)) else $error("hold after"); // R18
  chk_no_global: assert property (@(posedge clk) disable iff (sys_rst)
    grant_io |-> global_r) else $error("io grant while disabled"); // R15
  chk_jump_pc: assert property (@(posedge clk) disable iff (sys_rst)
    trap && instr_class == CLS_JUMP |-> pc_inhibit) else $error("jump not inhibited"); // R17
  chk_preset_off: assert property (@(posedge clk) disable iff (sys_rst)
    halted && preset_switch |=> !protect_r) else $error("preset failed"); // R08

  cov_trap: cover property (@(posedge clk) trap);
  cov_dma_both: cover property (@(posedge clk) grant_dma1 && dma2_done);
  cov_io_grant: cover property (@(posedge clk) grant_io);
  cov_reenable: cover property (@(posedge clk) !protect_r ##1 protect_r);
endmodule // fence_protect_interrupt_gate

// [fence_pkg.sv]
package fence_pkg;
  localparam int ADDR_W = 15;
  localparam int SC_W = 6;
  localparam logic [SC_W-1:0] SC_GLOBAL = 6'h00;
  localparam logic [SC_W-1:0] SC_SWITCH = 6'h01;
  localparam logic [SC_W-1:0] SC_PROTECT = 6'h05;
  localparam logic [ADDR_W-1:0] PROT_LOW = 15'h0002;
  localparam logic [ADDR_W-1:0] VEC_PROTECT = 15'h0005;
  localparam logic [ADDR_W-1:0] VEC_DMA1 = 15'h0006;
  localparam logic [ADDR_W-1:0] VEC_DMA2 = 15'h0007;
  localparam logic [ADDR_W-1:0] VEC_IO_BASE = 15'h0008;
  localparam int IO_CHANNELS = 56;
  localparam int IND_HOLD_LIMIT = 3;
  localparam int INT_HOLD_PHASES = 2;
  localparam int FAULT_PARITY_BIT = 15;
  localparam logic [ADDR_W-1:0] BOUNDARY_RESET = 15'h0000;
  localparam logic [15:0] FAULT_RESET = 16'h0000;
  typedef enum logic [3:0] {
    CLS_OTHER = 4'h0, CLS_JUMP = 4'h1, CLS_CALL = 4'h2, CLS_ISZ = 4'h3,
    CLS_STORE_A = 4'h4, CLS_STORE_B = 4'h5, CLS_DSTORE = 4'h6,
    CLS_SET_CTL = 4'h7, CLS_CLR_CTL = 4'h8, CLS_SET_FLG = 4'h9,
    CLS_CLR_FLG = 4'hA, CLS_OUT = 4'hB, CLS_IN = 4'hC, CLS_IO_OTHER = 4'hD
  } instr_class_t;
endpackage

// [seq_model.sv]
`timescale 1ns/1ps
module seq_model
  import fence_pkg::*;
(
  // Clock, reset and request.
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire fence_pkg::instr_class_t cls_q,
  input wire logic [fence_pkg::SC_W-1:0] sc_q,
  input wire logic [fence_pkg::ADDR_W-1:0] ia_q,
  input wire logic [fence_pkg::ADDR_W-1:0] ea_q,
  input wire logic [1:0] nind_q,
  // Sequencer outputs.
  output fence_pkg::instr_class_t instr_class,
  output logic [fence_pkg::SC_W-1:0] select_code,
  output logic instr_indirect,
  output logic [fence_pkg::ADDR_W-1:0] instr_addr,
  output logic [fence_pkg::ADDR_W-1:0] eff_addr,
  output logic fetch_done,
  output logic indirect_done,
  output logic execute_done,
  output logic cycle_end,
  // Observed results.
  input wire logic suppress,
  input wire logic pc_inhibit,
  input wire logic read_valid,
  input wire logic [15:0] read_data,
  output logic busy,
  output logic sup_r,
  output logic pci_r,
  output logic [15:0] rd_r
);
  logic [2:0] st;
  logic [1:0] left;
  assign busy = (st != 3'h0);
  initial begin
    {st, left, fetch_done, indirect_done, execute_done, cycle_end} = '0;
    {instr_class, select_code, instr_indirect, instr_addr, eff_addr} = '0;
  end
  // Each phase ends one machine cycle; the address is only valid at execute.
  always @(posedge clk) begin
    {fetch_done, indirect_done, execute_done, cycle_end} <= 4'h0;
    if (sys_rst) begin
      st <= 3'h0;
    end else begin
      case (st)
        3'h0: if (go) begin
          {instr_class, select_code, instr_addr} <= {cls_q, sc_q, ia_q};
          instr_indirect <= (nind_q != 2'h0);
          eff_addr <= ~ea_q;
          left <= nind_q;
          {sup_r, pci_r, rd_r} <= '0;
          st <= 3'h1;
        end
        3'h1: begin
          {fetch_done, cycle_end} <= 2'h3;
          st <= (left != 2'h0) ? 3'h2 : 3'h3;
        end
        3'h2: begin
          {indirect_done, cycle_end} <= 2'h3;
          left <= left - 2'h1;
          if (left == 2'h1) st <= 3'h3;
        end
        3'h3: begin
          eff_addr <= ea_q;
          {execute_done, cycle_end} <= 2'h3;
          st <= 3'h4;
        end
        default: st <= (st == 3'h7) ? 3'h0 : st + 3'h1;
      endcase
      if (execute_done) {sup_r, pci_r} <= {suppress, pc_inhibit};
      if (read_valid) rd_r <= read_data;
    end
  end
endmodule // seq_model

// [fence_protect_interrupt_gate_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module fence_protect_interrupt_gate_tb;
  import fence_pkg::*;
  logic clk = 0, sys_rst = 1, go = 0, halted = 0, preset_switch = 0, parity_error = 0;
  logic dma_word_xfer = 0, dma1_done = 0, dma2_done = 0;
  logic [15:0] acc_in = 16'h0000;
  logic [14:0] parity_addr = 15'h0000, ia_q = 0, ea_q = 0;
  logic [55:0] dev_flag = '0, dev_control = '0;
  instr_class_t cls_q = CLS_OTHER, instr_class;
  logic [5:0] sc_q = 0, select_code;
  logic [1:0] nind_q = 0;
  logic instr_indirect, fetch_done, indirect_done, execute_done, cycle_end, busy, sup_r, pci_r;
  logic suppress, pc_inhibit, read_valid, int_grant, protect_on, global_enable, parity_enable;
  logic [14:0] instr_addr, eff_addr, int_vector;
  logic [15:0] read_data, rd_r;
  logic [14:0] vecs[$];
  int err_count = 0, compares = 0, cyc = 0;
  always #20 clk = ~clk;
  seq_model seq (.clk(clk), .sys_rst(sys_rst), .go(go), .cls_q(cls_q), .sc_q(sc_q),
    .ia_q(ia_q), .ea_q(ea_q), .nind_q(nind_q), .instr_class(instr_class),
    .select_code(select_code), .instr_indirect(instr_indirect), .instr_addr(instr_addr),
    .eff_addr(eff_addr), .fetch_done(fetch_done), .indirect_done(indirect_done),
    .execute_done(execute_done), .cycle_end(cycle_end), .suppress(suppress),
    .pc_inhibit(pc_inhibit), .read_valid(read_valid), .read_data(read_data), .busy(busy),
    .sup_r(sup_r), .pci_r(pci_r), .rd_r(rd_r));
  fence_protect_interrupt_gate uut (.clk(clk), .sys_rst(sys_rst), .instr_class(instr_class),
    .select_code(select_code), .instr_indirect(instr_indirect), .instr_addr(instr_addr),
    .eff_addr(eff_addr), .fetch_done(fetch_done), .indirect_done(indirect_done),
    .execute_done(execute_done), .cycle_end(cycle_end), .halted(halted),
    .preset_switch(preset_switch), .intloc_is_io(1'b0), .acc_in(acc_in),
    .parity_error(parity_error), .parity_addr(parity_addr), .dma_word_xfer(dma_word_xfer),
    .dma1_done(dma1_done), .dma2_done(dma2_done), .dev_flag(dev_flag),
    .dev_control(dev_control), .suppress(suppress), .pc_inhibit(pc_inhibit),
    .read_data(read_data), .read_valid(read_valid), .int_grant(int_grant),
    .int_vector(int_vector), .protect_on(protect_on), .global_enable(global_enable),
    .parity_enable(parity_enable));
  // Records each grant and lets the serviced source drop its request.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
    if (int_grant) begin
      vecs.push_back(int_vector);
      if (int_vector == VEC_DMA1) dma1_done <= 1'b0;
      if (int_vector == VEC_DMA2) dma2_done <= 1'b0;
      if (int_vector >= VEC_IO_BASE) dev_flag[int_vector - VEC_IO_BASE] <= 1'b0;
    end
  end
  task automatic finish_test();
    $display("err_count=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic run(input instr_class_t c, input logic [5:0] s, input logic [14:0] a, e,
                     input logic [1:0] n);
    int k;
    @(posedge clk);
    {cls_q, sc_q, ia_q, ea_q, nind_q, go} <= {c, s, a, e, n, 1'b1};
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    #1;
    while (busy && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 40) begin
      err_count++;
      finish_test();
    end
  endtask
  task automatic t_reset();
    `CHK({protect_on, global_enable}, 2'b00)
    run(CLS_IN, SC_PROTECT, 15'h0100, 15'h0000, 2'h0);
    `CHK(rd_r, FAULT_RESET)
  endtask
  task automatic t_fence();
    instr_class_t cl[9] = '{CLS_STORE_A, CLS_STORE_B, CLS_ISZ, CLS_DSTORE, CLS_CALL,
                            CLS_JUMP, CLS_OTHER, CLS_OUT, CLS_IO_OTHER};
    logic [14:0] ea[9] = '{15'h000F, 15'h0010, 15'h0002, 15'h0001, 15'h0001, 15'h0001,
                           15'h0003, 15'h0400, 15'h0400};
    logic [5:0] sc[9] = '{0, 0, 0, 0, 0, 0, 0, 6'h01, 6'h03};
    bit ex[9] = '{1, 0, 1, 0, 0, 1, 0, 0, 1};
    acc_in <= 16'h0010;
    run(CLS_OUT, SC_PROTECT, 15'h0100, 15'h0000, 2'h0);
    for (int i = 0; i < 9; i++) begin
      run(CLS_SET_CTL, SC_PROTECT, 15'h0100, 15'h0000, 2'h0);
      `CHK(protect_on, 1'b1)
      vecs.delete();
      run(cl[i], sc[i], 15'h0200 + 15'(i), ea[i], 2'(i % 3));
      `CHK(sup_r, ex[i])
      `CHK(pci_r, ex[i] && cl[i] == CLS_JUMP)
      `CHK(vecs.size(), ex[i] ? 1 : 0)
      if (ex[i]) begin
        `CHK(vecs[0], VEC_PROTECT)
        `CHK(protect_on, 1'b0)
        run(CLS_IN, SC_PROTECT, 15'h0300, 15'h0000, 2'h0);
        `CHK(rd_r, {1'b0, 15'h0200 + 15'(i)})
      end else begin
        {halted, preset_switch} <= 2'b11;
        repeat (2) @(posedge clk);
        {halted, preset_switch} <= 2'b00;
        @(posedge clk);
        #1;
        `CHK(protect_on, 1'b0)
      end
    end
  endtask
  task automatic t_parity();
    {parity_error, parity_addr} <= {1'b1, 15'h1234};
    @(posedge clk);
    parity_error <= 1'b0;
    run(CLS_IN, SC_PROTECT, 15'h0300, 15'h0000, 2'h0);
    `CHK(rd_r, 16'h9234)
    run(CLS_SET_FLG, SC_PROTECT, 15'h0300, 15'h0000, 2'h0);
    `CHK(parity_enable, 1'b1)
    run(CLS_CLR_FLG, SC_PROTECT, 15'h0300, 15'h0000, 2'h0);
    `CHK(parity_enable, 1'b0)
  endtask
  task automatic t_irq();
    run(CLS_SET_FLG, SC_GLOBAL, 15'h0400, 15'h0000, 2'h0);
    `CHK(global_enable, 1'b1)
    vecs.delete();
    {dma1_done, dma2_done} <= 2'b11;
    repeat (3) run(CLS_OTHER, 6'h00, 15'h0400, 15'h0000, 2'h0);
    `CHK({vecs[0], vecs[1]}, {VEC_DMA1, VEC_DMA2})
    vecs.delete();
    {dma_word_xfer, dev_flag[5], dev_control[5]} <= 3'b111;
    dev_flag[55] <= 1'b1;
    dev_control[55] <= 1'b1;
    repeat (3) run(CLS_OTHER, 6'h00, 15'h0400, 15'h0000, 2'h0);
    `CHK(vecs.size(), 0)
    dma_word_xfer <= 1'b0;
    repeat (4) run(CLS_OTHER, 6'h00, 15'h0400, 15'h0000, 2'h0);
    `CHK({vecs[0], vecs[1]}, {15'h000D, 15'h003F})
    run(CLS_CLR_FLG, SC_GLOBAL, 15'h0400, 15'h0000, 2'h0);
    `CHK(global_enable, 1'b0)
    vecs.delete();
    dev_flag[7] <= 1'b1;
    dev_control[7] <= 1'b1;
    repeat (3) run(CLS_OTHER, 6'h00, 15'h0400, 15'h0000, 2'h0);
    `CHK(vecs.size(), 0)
  endtask
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_fence();
    t_parity();
    t_irq();
    finish_test();
  end
endmodule // fence_protect_interrupt_gate_tb
